// *** logic/fbs_params.svh ***
/*
  Constants of the field bus slave I/O and status block: register offsets,
  bit positions, reset values and timing figures.
  Assumes it is included by its bare name from the package and the module.
*/
`ifndef FBS_PARAMS_SVH
`define FBS_PARAMS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define FBS_OFS_ADDR 8'h00
`define FBS_OFS_STAT 8'h04
`define FBS_OFS_ISTAT 8'h08
`define FBS_OFS_IMASK 8'h0C

// ****************************************************************
// Address values and status detail bit positions
// ****************************************************************
`define FBS_ADDR_MAX 9'h0FE
`define FBS_DEF_NEW 9'h1FF
`define FBS_DEF_OLD 9'h0FF
`define FBS_SD_LINEV 0
`define FBS_SD_IOPWR 5

// ****************************************************************
// Interrupt bit positions
// ****************************************************************
`define FBS_IRQ_LINEV 0
`define FBS_IRQ_IOPWR 1
`define FBS_IRQ_DUP 2
`define FBS_IRQ_MISM 3
`define FBS_IRQ_ADDR 4

// ****************************************************************
// Timing
// ****************************************************************
`define FBS_CLK_KHZ 40000
`define FBS_FLASH_HALF_MS 250
`define FBS_FLASH_HALF_CYC (`FBS_FLASH_HALF_MS * `FBS_CLK_KHZ)

`endif

// *** logic/fbs_pkg.sv ***
/*
  Types of the field bus slave I/O and status block.
  Assumes the constants header is on the include path.
*/
`include "fbs_params.svh"

package fbs_pkg;
  typedef struct packed {
    logic [19:0] sync1;
    logic [19:0] sync2;
    logic [8:0] addr;
    logic [7:0] load;
    logic in_bit;
    logic in_en;
    logic dup;
    logic unreg;
    logic mism;
    logic [4:0] istat;
    logic [4:0] imask;
    logic [23:0] flash_cnt;
    logic flash;
    logic linev_q;
    logic iopwr_q;
    logic link_lamp;
    logic alarm_lamp;
    logic [15:0] status;
    logic dp_wr;
    logic [7:0] dp_ofs;
    logic [31:0] hrdata;
  } fbs_state_s;
endpackage

// *** logic/fbs_io_status.sv ***
/*
  Slave-side logic of a compact field bus I/O terminal: frame bit mapping
  of sensor and load points, status detail bits, indicator lamps, an
  AHB-Lite register slave and one interrupt output.
  Assumes the link decoder on the same clock presents one frame bit per
  strobe with its bit number, and that the level inputs for line voltage,
  I/O supply and signal quality come from pins on another clock domain.
*/
`include "fbs_params.svh"

module fbs_io_status
  import fbs_pkg::*;
#(
  parameter int N_SENSOR = 8,
  parameter int N_LOAD = 8,
  parameter bit NEW_FW = 1'b1,
  parameter int FLASH_HALF_CYC = `FBS_FLASH_HALF_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  input wire logic [15:0] sensor_point,
  output logic [7:0] load_point,
  output logic [15:0] sensor_lamp,
  output logic [7:0] load_lamp,
  input wire logic line_volt_low,
  input wire logic io_supply_low,
  input wire logic sig_present,
  input wire logic sig_error,
  input wire logic frame_strobe,
  input wire logic [8:0] frame_bit_num,
  input wire logic frame_out_bit,
  output logic frame_in_bit,
  output logic frame_in_en,
  input wire logic dup_report,
  input wire logic unreg_report,
  input wire logic mism_report,
  input wire logic addr_wr_strobe,
  input wire logic [8:0] addr_wr_data,
  output logic [8:0] addr_rd_data,
  output logic link_lamp,
  output logic alarm_lamp,
  output logic [15:0] status_detail
);

  localparam logic [8:0] DEF_ADDR = NEW_FW ? `FBS_DEF_NEW : `FBS_DEF_OLD;
  localparam logic [23:0] FLASH_LAST = 24'(FLASH_HALF_CYC - 1);
  localparam logic [9:0] NS = 10'(N_SENSOR);
  localparam logic [9:0] NL = 10'(N_LOAD);

  fbs_state_s s;
  fbs_state_s next_s;

  // ****************************************************************
  // Synchronised pin levels
  // ****************************************************************
  logic [15:0] sens;
  logic linev;
  logic iopwr;
  logic sig_ok;
  logic sig_err;
  assign sens = s.sync2[15:0];
  assign linev = s.sync2[16];
  assign iopwr = s.sync2[17];
  assign sig_ok = s.sync2[18];
  assign sig_err = s.sync2[19];

  logic is_default;
  logic [9:0] ofs;
  logic in_win;
  logic dp_take;
  logic [4:0] iev;
  logic [4:0] iclr;
  logic alt;
  logic unreg_now;

  // The frame offset is taken in ten bits so that a bit number below the
  // stored address wraps far out of every window instead of aliasing.
  assign is_default = (s.addr == DEF_ADDR);
  assign ofs = {1'b0, frame_bit_num} - {1'b0, s.addr};
  assign in_win = frame_strobe && !is_default && (frame_bit_num >= s.addr);
  assign dp_take = hsel && htrans[1] && hready;
  assign iclr = (s.dp_wr && s.dp_ofs == `FBS_OFS_ISTAT) ? hwdata[4:0] : '0;
  assign unreg_now = NEW_FW ? (is_default && sig_ok && !sig_err &&
                               !linev && !iopwr) : s.unreg;
  assign alt = s.dup || unreg_now;

  always_comb begin
    next_s = s;
    next_s.sync1 = {sig_error, sig_present, io_supply_low, line_volt_low,
                    sensor_point};
    next_s.sync2 = s.sync1;
    next_s.linev_q = linev;
    next_s.iopwr_q = iopwr;

    // ****************************************************************
    // Address store: writer tool and software
    // ****************************************************************
    // Out-of-range writes are dropped; the default value is accepted so
    // that a terminal can be returned to the unset state.
    if (addr_wr_strobe && (addr_wr_data <= `FBS_ADDR_MAX ||
        addr_wr_data == DEF_ADDR)) begin
      next_s.addr = addr_wr_data;
    end else if (s.dp_wr && s.dp_ofs == `FBS_OFS_ADDR &&
                 (hwdata[8:0] <= `FBS_ADDR_MAX ||
                  hwdata[8:0] == DEF_ADDR)) begin
      next_s.addr = hwdata[8:0];
    end
    if (next_s.addr != s.addr) begin
      next_s.dup = 1'b0;
      next_s.unreg = 1'b0;
      next_s.mism = 1'b0;
    end
    if (dup_report) begin
      next_s.dup = 1'b1;
    end
    if (unreg_report && !NEW_FW) begin
      next_s.unreg = 1'b1;
    end
    if (mism_report && NEW_FW) begin
      next_s.mism = 1'b1;
    end

    // ****************************************************************
    // Frame exchange
    // ****************************************************************
    next_s.in_en = 1'b0;
    next_s.in_bit = 1'b0;
    if (in_win && ofs < NS) begin
      next_s.in_en = 1'b1;
      next_s.in_bit = sens[ofs[3:0]];
    end
    if (in_win && ofs < NL) begin
      next_s.load[ofs[2:0]] = frame_out_bit;
    end
    if (is_default) begin
      next_s.load = '0;
    end

    // ****************************************************************
    // Status detail and lamps
    // ****************************************************************
    next_s.status = '0;
    next_s.status[`FBS_SD_LINEV] = linev;
    next_s.status[`FBS_SD_IOPWR] = iopwr;

    if (s.flash_cnt == FLASH_LAST) begin
      next_s.flash_cnt = '0;
      next_s.flash = !s.flash;
    end else begin
      next_s.flash_cnt = s.flash_cnt + 24'h000001;
    end

    if (alt) begin
      next_s.link_lamp = s.flash;
      next_s.alarm_lamp = !s.flash;
    end else if (s.mism) begin
      next_s.link_lamp = 1'b1;
      next_s.alarm_lamp = s.flash;
    end else begin
      next_s.link_lamp = sig_err ? 1'b1 : (sig_ok & s.flash);
      next_s.alarm_lamp = iopwr ? 1'b1 : (linev & s.flash);
    end

    // ****************************************************************
    // Interrupts and bus slave
    // ****************************************************************
    iev = '0;
    iev[`FBS_IRQ_LINEV] = linev && !s.linev_q;
    iev[`FBS_IRQ_IOPWR] = iopwr && !s.iopwr_q;
    iev[`FBS_IRQ_DUP] = dup_report;
    iev[`FBS_IRQ_MISM] = mism_report && NEW_FW;
    iev[`FBS_IRQ_ADDR] = next_s.addr != s.addr;
    // A new event in the clearing cycle survives the clear.
    next_s.istat = (s.istat & ~iclr) | iev;
    if (s.dp_wr && s.dp_ofs == `FBS_OFS_IMASK) begin
      next_s.imask = hwdata[4:0];
    end

    next_s.dp_wr = dp_take && hwrite;
    next_s.dp_ofs = haddr[7:0];
    if (dp_take && !hwrite) begin
      unique case (haddr[7:0])
        `FBS_OFS_ADDR: next_s.hrdata = {23'h000000, s.addr};
        `FBS_OFS_STAT: next_s.hrdata = {11'h000, s.dup, unreg_now, s.mism,
                                        alarm_lamp, link_lamp, s.status};
        `FBS_OFS_ISTAT: next_s.hrdata = {27'h0000000, s.istat};
        `FBS_OFS_IMASK: next_s.hrdata = {27'h0000000, s.imask};
        default: next_s.hrdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.addr <= NEW_FW ? `FBS_DEF_NEW : `FBS_DEF_OLD;
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.hrdata;
  assign irq = |(s.istat & s.imask);
  assign load_point = s.load;
  assign load_lamp = s.load;
  assign sensor_lamp = sens;
  assign frame_in_bit = s.in_bit;
  assign frame_in_en = s.in_en;
  assign addr_rd_data = s.addr;
  assign link_lamp = s.link_lamp;
  assign alarm_lamp = s.alarm_lamp;
  assign status_detail = s.status;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_addr_legal: assert property (
    s.addr <= `FBS_ADDR_MAX || s.addr == DEF_ADDR)
    else $error("stored address out of range");
  a_in_place: assert property (
    (in_win && ofs < NS) |=> frame_in_en &&
      frame_in_bit == $past(sens[ofs[3:0]]))
    else $error("sensor bit not placed at its frame offset");
  a_load_place: assert property (
    (in_win && ofs < NL && !is_default && !addr_wr_strobe && !s.dp_wr)
      |=> load_point[$past(ofs[2:0])] == $past(frame_out_bit))
    else $error("load bit not taken from its frame offset");
  a_default_mute: assert property (
    is_default |=> !frame_in_en && load_point == 8'h00)
    else $error("I/O active with default address");
  a_readback: assert property (
    (addr_wr_strobe && addr_wr_data <= `FBS_ADDR_MAX)
      |=> addr_rd_data == $past(addr_wr_data))
    else $error("written address not read back");
  a_sd_bits: assert property (
    ##1 status_detail[`FBS_SD_LINEV] == $past(linev) &&
      status_detail[`FBS_SD_IOPWR] == $past(iopwr))
    else $error("status detail bits do not follow drops");
  a_link_dark: assert property (
    (!alt && !s.mism && !sig_ok && !sig_err) |=> !link_lamp)
    else $error("link lamp lit without signal");
  a_alarm_lit: assert property (
    (!alt && !s.mism && iopwr) |=> alarm_lamp)
    else $error("alarm lamp dark on supply drop");
  a_mism_show: assert property (
    (!alt && s.mism) |=> link_lamp && alarm_lamp == $past(s.flash))
    else $error("replacement failure not shown");
  a_alt_flash: assert property (
    alt |=> link_lamp != alarm_lamp)
    else $error("lamps not alternating");

  c_dup: cover property (dup_report ##1 alt);
  c_mism: cover property (s.mism && !alt ##1 link_lamp);
  c_load: cover property (in_win && ofs < NL);
  c_irq: cover property ($rose(irq));
endmodule

// *** verif/fbs_link_model.sv ***
/*
  Behavioural far side of the field bus slave block: the bus master that
  strobes frame bits and the address writer tool.
  Assumes the testbench calls its tasks and feeds it the pin levels.
*/
module fbs_link_model (
  input wire logic hclk,
  input wire logic line_ok,
  input wire logic supply_ok,
  output logic frame_strobe,
  output logic [8:0] frame_bit_num,
  output logic frame_out_bit,
  output logic addr_wr_strobe,
  output logic [8:0] addr_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    frame_strobe = 1'b0;
    frame_bit_num = 9'h155;
    frame_out_bit = 1'b0;
    addr_wr_strobe = 1'b0;
    addr_wr_data = 9'h0AA;
  end
  // Released lines show the inverse so stale values are never mistaken.
  task send_bit(input logic [8:0] num, input logic ob);
    @(posedge hclk);
    frame_strobe <= 1'b1;
    frame_bit_num <= num;
    frame_out_bit <= ob;
    @(posedge hclk);
    frame_strobe <= 1'b0;
    frame_bit_num <= ~num;
    frame_out_bit <= ~ob;
  endtask
  // Writes only while the line signal is clean and the I/O supply is up.
  task write_addr(input logic [8:0] a);
    if (line_ok && supply_ok) begin
      @(posedge hclk);
      addr_wr_strobe <= 1'b1;
      addr_wr_data <= a;
      @(posedge hclk);
      addr_wr_strobe <= 1'b0;
      addr_wr_data <= ~a;
      @(posedge hclk);
    end
  endtask
endmodule

// *** verif/tb.sv ***
/*
  Self-checking testbench of the field bus slave I/O and status block.
  Assumes the link model file is compiled first.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] sensor_point, sensor_lamp, status_detail;
  logic [7:0] load_point, load_lamp;
  logic line_volt_low, io_supply_low, sig_present, sig_error;
  logic frame_strobe, frame_out_bit, frame_in_bit, frame_in_en;
  logic [8:0] frame_bit_num, addr_wr_data, addr_rd_data;
  logic dup_report, unreg_report, mism_report, addr_wr_strobe;
  logic line_ok, supply_ok;
  logic link_lamp, alarm_lamp;
  logic old_link, old_alarm;
  logic [8:0] old_addr;
  int mismatches, checks_done;
  assign hready = hreadyout;
  assign line_ok = sig_present & ~sig_error;
  assign supply_ok = ~io_supply_low;
  fbs_io_status #(.FLASH_HALF_CYC(4)) dut (.*);
  fbs_link_model lm (.*);
  // Second terminal with the older firmware behaviour; only its address
  // and lamps are watched, the rest of its outputs are left open.
  fbs_io_status #(.NEW_FW(1'b0), .FLASH_HALF_CYC(4)) dut_old (
    .*,
    .hreadyout(),
    .hresp(),
    .hrdata(),
    .irq(),
    .load_point(),
    .sensor_lamp(),
    .load_lamp(),
    .frame_in_bit(),
    .frame_in_en(),
    .addr_rd_data(old_addr),
    .link_lamp(old_link),
    .alarm_lamp(old_alarm),
    .status_detail()
  );
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task ahb(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task pins(input logic lv, sv, sp, se);
    @(posedge hclk);
    line_volt_low <= lv;
    io_supply_low <= sv;
    sig_present <= sp;
    sig_error <= se;
    repeat (6) @(posedge hclk);
  endtask
  task pulse(input logic d, m);
    @(posedge hclk);
    dup_report <= d;
    mism_report <= m;
    @(posedge hclk);
    dup_report <= 1'b0;
    mism_report <= 1'b0;
  endtask
  function int cls(input int c);
    return c == 0 ? 0 : (c == 16 ? 2 : 1);
  endfunction
  // Lamp codes: 0 dark, 1 flashing, 2 lit; alt asks for opposite phases.
  task lamps(input int el, ea, input bit alt);
    int l, a, s;
    l = 0;
    a = 0;
    s = 0;
    repeat (16) begin
      @(posedge hclk);
      #1;
      l += int'(link_lamp === 1'b1);
      a += int'(alarm_lamp === 1'b1);
      s += int'(link_lamp === alarm_lamp);
    end
    chk(cls(l), el);
    chk(cls(a), ea);
    if (alt) chk(s, 0);
  endtask
  task t_reset;
    chk(addr_rd_data, 9'h1FF);
    ahb(1'b0, 32'h00, 32'h0);
    chk(rd, 32'h1FF);
    pins(1'b0, 1'b0, 1'b1, 1'b0);
    lamps(1, 1, 1'b1);
    chk(old_addr, 9'h0FF);
    chk(old_alarm, 1'b0);
    @(posedge hclk);
    unreg_report <= 1'b1;
    @(posedge hclk);
    unreg_report <= 1'b0;
    repeat (2) @(posedge hclk);
    #1;
    chk(old_link ^ old_alarm, 1'b1);
    lm.send_bit(9'h000, 1'b1);
    #1;
    chk(frame_in_en, 1'b0);
    chk(load_point, 8'h00);
    $display("test reset done");
  endtask
  task t_frame;
    lm.write_addr(9'h00A);
    #1;
    chk(addr_rd_data, 9'h00A);
    lamps(1, 0, 1'b0);
    lm.send_bit(9'h00C, 1'b1);
    #1;
    chk(frame_in_en, 1'b1);
    chk(frame_in_bit, 1'b1);
    chk(load_point, 8'h04);
    chk(load_lamp, 8'h04);
    chk(sensor_lamp[7:0], 8'hA5);
    lm.send_bit(9'h00D, 1'b0);
    #1;
    chk(frame_in_bit, 1'b0);
    lm.send_bit(9'h011, 1'b1);
    #1;
    chk({frame_in_en, frame_in_bit, load_point}, 10'h384);
    lm.send_bit(9'h009, 1'b1);
    #1;
    chk(frame_in_en, 1'b0);
    lm.send_bit(9'h012, 1'b1);
    #1;
    chk({frame_in_en, load_point}, 9'h084);
    $display("test frame done");
  endtask
  task t_bus_addr;
    ahb(1'b1, 32'h00, 32'h0FF);
    ahb(1'b0, 32'h00, 32'h0);
    chk(rd, 32'h00A);
    ahb(1'b1, 32'h00, 32'h0FE);
    ahb(1'b0, 32'h00, 32'h0);
    chk(rd, 32'h0FE);
    chk(addr_rd_data, 9'h0FE);
    ahb(1'b0, 32'h10, 32'h0);
    chk(rd, 32'h0);
    chk(hresp, 1'b0);
    lm.send_bit(9'h105, 1'b1);
    #1;
    chk({frame_in_en, frame_in_bit}, 2'b11);
    $display("test bus address done");
  endtask
  task t_status;
    pins(1'b1, 1'b0, 1'b1, 1'b0);
    chk(status_detail, 16'h0001);
    lamps(1, 1, 1'b0);
    ahb(1'b0, 32'h04, 32'h0);
    chk(rd[15:0], 16'h0001);
    chk(irq, 1'b0);
    ahb(1'b1, 32'h0C, 32'h01);
    @(posedge hclk);
    #1;
    chk(irq, 1'b1);
    ahb(1'b1, 32'h08, 32'h01);
    @(posedge hclk);
    #1;
    chk(irq, 1'b0);
    pins(1'b0, 1'b1, 1'b1, 1'b1);
    chk(status_detail, 16'h0020);
    lamps(2, 2, 1'b0);
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    lamps(0, 0, 1'b0);
    $display("test status done");
  endtask
  task t_reports;
    pins(1'b0, 1'b0, 1'b1, 1'b0);
    pulse(1'b1, 1'b0);
    lamps(1, 1, 1'b1);
    lm.write_addr(9'h020);
    lamps(1, 0, 1'b0);
    pulse(1'b0, 1'b1);
    lamps(2, 1, 1'b0);
    ahb(1'b0, 32'h08, 32'h0);
    chk(rd, 32'h1E);
    $display("test reports done");
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {dup_report, unreg_report, mism_report} = '0;
    {line_volt_low, io_supply_low, sig_present, sig_error} = '0;
    hsize = 3'b010;
    sensor_point = 16'h00A5;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_frame();
    t_bus_addr();
    t_status();
    t_reports();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    close_out();
  end
endmodule
